// file: ihr_top.sv
// per-channel 2x interpolating half-band and six-stream output router
// Functional notes
// - 22-bit I/Q in, rounded 22-bit I/Q out
// - fixed eleven-tap half-band, no programmable coefficients
// - taps 14, -66, 309, centre 512
// - two outputs per input, image filtered
// - half-band only when control bit 9 set
// - interleave stage then pair-combining stage to AGCs
// - merged stream rate is sum of members
// - phase-0 channel even outputs, phase-1 odd in two-channel groups
// - 4-bit grouping code, illegal means independent
// - codes 0-4 merge ch0 with ch1..N
// - codes 5-9 give the fixed split groupings
// - complex: I=ICi-QCq, Q=ICq+QCi
// - complex codes 1-3 pair 0/1, 2/3, 4/5
// - biphase codes 5-7 pair 0/1, 2/3, 4/5
// - code 000 disables pairing entirely
// - pair result leaves on lower stream only
// - biphase sums even and odd stream products
`default_nettype none
module ihr_top #(
	parameter int FIFO_DEPTH = ihr_pkg::FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [5:0] i_ch_valid,
	input wire ihr_pkg::ihr_iq_t [5:0] i_ch_data,
	output logic [5:0] o_ch_ready,
	input wire logic [15:0] i_mono_ctrl [6],
	input wire logic [3:0] i_stream_ctrl,
	input wire logic [2:0] i_complex_ctrl,
	output logic [5:0] o_agc_valid,
	output ihr_pkg::ihr_iq_t [5:0] o_agc_data,
	input wire logic [5:0] i_agc_ready,
	output logic [5:0] o_agc_used
);
	localparam int N = ihr_pkg::NUM_CH;
	localparam int W = ihr_pkg::SMP_W;
	localparam int AW = ihr_pkg::ACC_W;
	localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
	localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};
	if (FIFO_DEPTH < 2)
		$error("output fifo depth too small");
	if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
		$error("output fifo depth must be a power of two");
	if (N != 6)
		$error("router is built for exactly six channels");

	// saturate a wide signed value to the sample width
	function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
		logic signed [AW-1:0] hi;
		logic signed [AW-1:0] lo;
		hi = AW'(SMAX);
		lo = AW'(SMIN);
		if (v > hi)
			sat = SMAX;
		else if (v < lo)
			sat = SMIN;
		else
			sat = v[W-1:0];
	endfunction

	// odd polyphase branch: midpoint between h[2] and h[3]
	function automatic logic signed [W-1:0] hb_mid(
		input logic signed [W-1:0] h0, input logic signed [W-1:0] h1,
		input logic signed [W-1:0] h2, input logic signed [W-1:0] h3,
		input logic signed [W-1:0] h4, input logic signed [W-1:0] h5);
		logic signed [AW-1:0] acc;
		acc = AW'(ihr_pkg::HB_C1) * (AW'(h0) + AW'(h5))
			+ AW'(ihr_pkg::HB_C3) * (AW'(h1) + AW'(h4))
			+ AW'(ihr_pkg::HB_C5) * (AW'(h2) + AW'(h3));
		acc = acc + signed'(ihr_pkg::HB_ROUND);
		hb_mid = sat(acc >>> ihr_pkg::HB_SHIFT);
	endfunction

	// even branch: only the centre tap meets a real sample
	function automatic logic signed [W-1:0] hb_ctr(input logic signed [W-1:0] h);
		logic signed [AW-1:0] acc;
		acc = AW'(ihr_pkg::HB_C6) * AW'(h);
		acc = acc + signed'(ihr_pkg::HB_ROUND);
		hb_ctr = sat(acc >>> ihr_pkg::HB_SHIFT);
	endfunction

	logic [5:0] ch_v;
	ihr_pkg::ihr_iq_t [5:0] ch_d;
	logic [5:0] ch_take;

	// half-band stage, one per channel
	for (genvar c = 0; c < N; c++)
	begin : g_hb
		ihr_pkg::ihr_iq_t hist_ff [6];
		ihr_pkg::ihr_iq_t nh [6];
		ihr_pkg::ihr_iq_t out_ff;
		ihr_pkg::ihr_iq_t pend_ff;
		logic out_v_ff;
		logic pend_v_ff;
		// history moves only while interpolating; bypassed samples skip it
		wire hb_on = i_mono_ctrl[c][ihr_pkg::MONO_HB_BIT];
		// single output register halves throughput; the input rate limit
		// leaves more than two clocks per input sample
		wire accept = i_ch_valid[c] && !out_v_ff;
		ihr_pkg::ihr_iq_t even_s;
		ihr_pkg::ihr_iq_t odd_s;
		assign nh[0] = i_ch_data[c];
		for (genvar k = 1; k < 6; k++)
		begin : g_sh
			assign nh[k] = hist_ff[k-1];
		end
		assign even_s.i = hb_ctr(nh[3].i);
		assign even_s.q = hb_ctr(nh[3].q);
		assign odd_s.i = hb_mid(nh[0].i, nh[1].i, nh[2].i, nh[3].i, nh[4].i,
			nh[5].i);
		assign odd_s.q = hb_mid(nh[0].q, nh[1].q, nh[2].q, nh[3].q, nh[4].q,
			nh[5].q);
		assign o_ch_ready[c] = !out_v_ff;
		assign ch_v[c] = out_v_ff;
		assign ch_d[c] = out_ff;
		always_ff @(posedge i_sys_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				for (int k = 0; k < 6; k++)
					hist_ff[k] <= '0;
			end
			else if (accept && hb_on)
			begin
				for (int k = 0; k < 6; k++)
					hist_ff[k] <= nh[k];
			end
		end
		always_ff @(posedge i_sys_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				out_ff <= '0;
				pend_ff <= '0;
				out_v_ff <= 1'b0;
				pend_v_ff <= 1'b0;
			end
			else if (accept)
			begin
				out_ff <= hb_on ? even_s : i_ch_data[c];
				pend_ff <= odd_s;
				out_v_ff <= 1'b1;
				pend_v_ff <= hb_on;
			end
			else if (ch_take[c])
			begin
				out_ff <= pend_ff;
				out_v_ff <= pend_v_ff;
				pend_v_ff <= 1'b0;
			end
		end
	end

	// first router stage: interleave channel groups into streams
	logic [5:0] starts;
	wire code_ok = i_stream_ctrl <= ihr_pkg::STREAM_CODE_MAX;
	assign starts = code_ok ? ihr_pkg::GRP_MASK[i_stream_ctrl] :
		ihr_pkg::GRP_INDEP;
	// positions past the last channel count as group heads, so a pointer
	// that runs off the end always sees a group boundary
	logic [7:0] starts_x;
	assign starts_x = {2'b11, starts};

	logic [5:0] st_v_ff;
	ihr_pkg::ihr_iq_t [5:0] st_d_ff;
	logic [5:0] st_pop;
	logic [5:0] st_take;
	logic [5:0] take_mat [6];

	for (genvar s = 0; s < N; s++)
	begin : g_il
		logic [2:0] ptr_ff;
		logic [2:0] nxt_ptr;
		wire [2:0] base = 3'(s);
		wire [2:0] sel = base + ptr_ff;
		wire sel_ok = (sel < 3'(N)) && (ptr_ff == 3'h0 || !starts_x[sel]);
		wire [2:0] sel_nx = sel + 3'h1;
		wire grp_end = starts_x[sel_nx];
		wire space = !st_v_ff[s] || st_pop[s];
		// member channels are polled strictly in turn, so in a two-channel group
		// the phase-0 channel always lands on even slots and phase-1 on odd
		assign st_take[s] = starts[s] && sel_ok && ch_v[sel] && space;
		for (genvar c = 0; c < N; c++)
		begin : g_tm
			assign take_mat[c][s] = st_take[s] && (sel == 3'(c));
		end
		always_comb
		begin
			nxt_ptr = ptr_ff;
			if (!starts[s] || !sel_ok)
				nxt_ptr = 3'h0;
			else if (st_take[s])
				nxt_ptr = grp_end ? 3'h0 : ptr_ff + 3'h1;
		end
		always_ff @(posedge i_sys_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				ptr_ff <= 3'h0;
				st_v_ff[s] <= 1'b0;
				st_d_ff[s] <= '0;
			end
			else
			begin
				ptr_ff <= nxt_ptr;
				if (st_take[s])
				begin
					st_v_ff[s] <= 1'b1;
					st_d_ff[s] <= ch_d[sel];
				end
				else if (st_pop[s])
					st_v_ff[s] <= 1'b0;
			end
		end
	end

	// a channel is released by whichever stream currently points at it
	for (genvar c = 0; c < N; c++)
	begin : g_ct
		assign ch_take[c] = |take_mat[c];
	end

	// second router stage: complex completion or biphase summation per pair
	wire cpx_mode = i_complex_ctrl != ihr_pkg::CPX_OFF &&
		!i_complex_ctrl[2];
	wire bip_mode = i_complex_ctrl > ihr_pkg::CPX_BIPH_BASE;
	// code 100 names no pairs and so falls through to plain streams
	wire [2:0] pair_cnt = cpx_mode ? i_complex_ctrl :
		bip_mode ? i_complex_ctrl - ihr_pkg::CPX_BIPH_BASE : 3'h0;

	logic [5:0] f_in_v;
	logic [5:0] f_in_rdy;
	ihr_pkg::ihr_iq_t [5:0] f_in_d;

	for (genvar p = 0; p < N / 2; p++)
	begin : g_pair
		localparam int A = 2 * p;
		localparam int B = 2 * p + 1;
		wire pair_on = pair_cnt > 3'(p);
		ihr_pkg::ihr_iq_t a;
		ihr_pkg::ihr_iq_t b;
		ihr_pkg::ihr_iq_t comb;
		assign a = st_d_ff[A];
		assign b = st_d_ff[B];
		// stream A carries the real-coefficient terms, B the imaginary ones
		logic signed [AW-1:0] cpx_i;
		logic signed [AW-1:0] cpx_q;
		logic signed [AW-1:0] bip_i;
		logic signed [AW-1:0] bip_q;
		assign cpx_i = AW'(a.i) - AW'(b.q);
		assign cpx_q = AW'(b.i) + AW'(a.q);
		assign bip_i = AW'(a.i) + AW'(b.i);
		assign bip_q = AW'(a.q) + AW'(b.q);
		assign comb.i = cpx_mode ? sat(cpx_i) : sat(bip_i);
		assign comb.q = cpx_mode ? sat(cpx_q) : sat(bip_q);
		wire both = st_v_ff[A] && st_v_ff[B];
		assign f_in_v[A] = pair_on ? both : st_v_ff[A];
		assign f_in_d[A] = pair_on ? comb : a;
		assign f_in_v[B] = pair_on ? 1'b0 : st_v_ff[B];
		assign f_in_d[B] = b;
		assign st_pop[A] = pair_on ? both && f_in_rdy[A] :
			st_v_ff[A] && f_in_rdy[A];
		assign st_pop[B] = pair_on ? both && f_in_rdy[A] :
			st_v_ff[B] && f_in_rdy[B];
		// usage follows the codes alone, so unused AGCs can be bypassed early
		assign o_agc_used[A] = starts[A] || (pair_on && starts[B]);
		assign o_agc_used[B] = starts[B] && !pair_on;
	end

	// output fifos give each AGC path its own back-pressure
	for (genvar s = 0; s < N; s++)
	begin : g_fifo
		ihr_fifo #(
			.WIDTH(2 * W),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.i_sys_clk(i_sys_clk),
			.i_rst_n(i_rst_n),
			.i_valid(f_in_v[s]),
			.i_data(f_in_d[s]),
			.o_ready(f_in_rdy[s]),
			.o_valid(o_agc_valid[s]),
			.o_data(o_agc_data[s]),
			.i_ready(i_agc_ready[s])
		);
	end
endmodule // ihr_top

// output fifo: valid and ready on both sides, depth a power of two
module ihr_fifo #(
	parameter int WIDTH = 44,
	parameter int DEPTH = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("fifo depth must be a power of two of at least 2");
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	assign o_ready = cnt_ff != FULL_CNT;
	assign o_valid = cnt_ff != '0;
	// the head slot is never rewritten: a full fifo refuses pushes
	assign o_data = mem_ff[rd_ff];
	always_ff @(posedge i_sys_clk)
	begin
		if (push)
			mem_ff[wr_ff] <= i_data;
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wr_ff <= push ? wr_ff + 1'b1 : wr_ff;
			rd_ff <= pop ? rd_ff + 1'b1 : rd_ff;
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // ihr_fifo
`default_nettype wire

// file: ihr_pkg.sv
// shared constants and types of the interpolating half-band and output router
`default_nettype none
package ihr_pkg;
	localparam int NUM_CH = 6;
	localparam int SMP_W = 22;
	localparam int ACC_W = 36;
	localparam int FIFO_DEPTH = 32;
	// half-band integer taps, 512 is unity gain
	localparam logic signed [10:0] HB_C1 = 11'sd14;
	localparam logic signed [10:0] HB_C3 = -11'sd66;
	localparam logic signed [10:0] HB_C5 = 11'sd309;
	localparam logic signed [10:0] HB_C6 = 11'sd512;
	localparam int HB_SHIFT = 9;
	localparam logic [ACC_W-1:0] HB_ROUND = 36'h000000100;
	// monorate_coef_filter control bit that turns the half-band on
	localparam int MONO_HB_BIT = 9;
	// group start masks per stream control code, bit c set: ch c heads a group
	localparam logic [3:0] STREAM_CODE_MAX = 4'h9;
	localparam logic [5:0] GRP_INDEP = 6'h3f;
	localparam logic [5:0] GRP_MASK [10] = '{6'h3d, 6'h39, 6'h31, 6'h21,
		6'h01, 6'h09, 6'h15, 6'h35, 6'h29, 6'h11};
	localparam logic [2:0] CPX_OFF = 3'h0;
	localparam logic [2:0] CPX_BIPH_BASE = 3'h4;
	typedef struct packed {
		logic signed [SMP_W-1:0] i;
		logic signed [SMP_W-1:0] q;
	} ihr_iq_t;
endpackage
`default_nettype wire

// file: ihr_fifo.sv
// holds no code: the output fifo module sits in ihr_top.sv with the router
`default_nettype none
`default_nettype wire

// file: ihr_top_assertions.sv
// port-level assertions and covers for the half-band router
`default_nettype none
module ihr_top_checker (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [5:0] i_ch_valid,
	input wire logic [5:0] o_ch_ready,
	input wire logic [3:0] i_stream_ctrl,
	input wire logic [2:0] i_complex_ctrl,
	input wire logic [5:0] o_agc_valid,
	input wire ihr_pkg::ihr_iq_t [5:0] o_agc_data,
	input wire logic [5:0] i_agc_ready,
	input wire logic [5:0] o_agc_used
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic [5:0] tk = i_ch_valid & o_ch_ready;
	wire logic [5:0] st = o_agc_valid & ~i_agc_ready;
	wire logic off = i_complex_ctrl == 3'h0;
	take_drop_a: assert property (tk != 6'h0
		|=> (o_ch_ready & $past(tk)) == 6'h0) else $error("ready after take");
	indep_used_a: assert property (i_stream_ctrl > 4'h9 && off
		|-> o_agc_used == 6'h3f) else $error("illegal code not independent");
	one_stream_a: assert property (i_stream_ctrl == 4'h4 && off
		|-> o_agc_used == 6'h01) else $error("code 4 not one stream");
	split_used_a: assert property (i_stream_ctrl == 4'h6 && off
		|-> o_agc_used == 6'h15) else $error("code 6 grouping wrong");
	cpx_pair_a: assert property (i_complex_ctrl == 3'h3
		|-> (o_agc_used & 6'h2a) == 6'h0) else $error("odd stream used");
	biph_used_a: assert property (i_stream_ctrl == 4'hf
		&& i_complex_ctrl == 3'h7 |-> o_agc_used == 6'h15)
		else $error("biphase usage wrong");
	hold_valid_a: assert property (st != 6'h0
		|=> (o_agc_valid & $past(st)) == $past(st)) else $error("valid lost");
	hold_data_a: assert property (st[0]
		|=> $stable(o_agc_data[0])) else $error("data moved while stalled");
	fast_out_a: assert property (tk[5] && i_stream_ctrl == 4'hf && off
		|-> ##[1:3] o_agc_valid[5]) else $error("stream 5 output late");
	take_c: cover property (tk[0]);
	pair_c: cover property (i_complex_ctrl == 3'h1 && o_agc_valid[0]);
	full_c: cover property (st[0] && !o_ch_ready[0]);
endmodule // ihr_top_checker
bind ihr_top ihr_top_checker u_chk (.i_sys_clk, .i_rst_n, .i_ch_valid,
	.o_ch_ready, .i_stream_ctrl, .i_complex_ctrl, .o_agc_valid, .o_agc_data,
	.i_agc_ready, .o_agc_used);
`default_nettype wire

// file: ihr_agc_model.sv
// agc-side sink: always ready, random ready or full stall
`default_nettype none
module ihr_agc_model (
	input wire logic i_sys_clk,
	input wire logic [1:0] i_mode,
	output logic [5:0] o_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rs = 32'h77e1;
	logic [1:0] mode;
	initial o_ready = 6'h3f;
	// mode is taken on the edge, before the bench moves it 1 ns later
	always @(posedge i_sys_clk)
	begin
		mode = i_mode;
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		#1 o_ready = mode == 2'h0 ? 6'h3f : mode == 2'h1 ? rs[5:0] : 6'h0;
	end
endmodule // ihr_agc_model
`default_nettype wire

// file: interp_halfband_output_router_tb_top.sv
// bench: random channel traffic against a queue model of the router
`default_nettype none
module interp_halfband_output_router_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0;
	logic [5:0] vld = 6'h0, rdy, used, ov, ar;
	ihr_pkg::ihr_iq_t [5:0] dat = '0, od;
	logic [15:0] mr [6] = '{default: 16'h0};
	logic [3:0] sc = 4'hf;
	logic [2:0] cc = 3'h0;
	logic [1:0] md = 2'h0;
	int error_cnt = 0, total_checks = 0;
	logic [31:0] rs = 32'h518c;
	ihr_pkg::ihr_iq_t q [6][$];
	ihr_pkg::ihr_iq_t hs [6][6];
	int ptr [6];
	localparam logic [5:0] HD [10] = '{6'h3d, 6'h39, 6'h31, 6'h21, 6'h01,
		6'h09, 6'h15, 6'h35, 6'h29, 6'h11};
	wire logic [5:0] hm = sc > 4'h9 ? 6'h3f : HD[sc];
	wire logic [5:0] um = hm & ~(6'h2a >> (6 - 2 * cc[1:0]));
	ihr_top u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ch_valid(vld),
		.i_ch_data(dat), .o_ch_ready(rdy), .i_mono_ctrl(mr),
		.i_stream_ctrl(sc), .i_complex_ctrl(cc), .o_agc_valid(ov),
		.o_agc_data(od), .i_agc_ready(ar), .o_agc_used(used));
	ihr_agc_model u_agc (.i_sys_clk(clk), .i_mode(md), .o_ready(ar));
	initial forever #12.5 clk = ~clk;
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [21:0] sat(longint v);
		return v > 64'sh1fffff ? 22'h1fffff : v < -64'sh200000 ? 22'h200000
			: 22'(v);
	endfunction
	function automatic logic [21:0] hbf(int c, bit iq);
		longint h [6];
		foreach (h[k]) h[k] = iq ? hs[c][k].q : hs[c][k].i;
		return sat((14 * (h[0] + h[5]) - 66 * (h[1] + h[4])
			+ 309 * (h[2] + h[3]) + 256) >>> 9);
	endfunction
	function automatic int qs();
		qs = 0;
		foreach (q[k]) qs += q[k].size();
	endfunction
	task automatic push(int c, ihr_pkg::ihr_iq_t x);
		if (!mr[c][9])
			q[c].push_back(x);
		else
		begin
			for (int k = 5; k > 0; k--)
				hs[c][k] = hs[c][k - 1];
			hs[c][0] = x;
			q[c].push_back(hs[c][3]);
			q[c].push_back({hbf(c, 0), hbf(c, 1)});
		end
	endtask
	// a group hands out its members in turn, lowest channel first
	function automatic ihr_pkg::ihr_iq_t nxt(int s);
		int c = ptr[s];
		ptr[s] = (c < 5 && !hm[c + 1]) ? c + 1 : s;
		if (q[c].size() == 0)
			return 'x;
		return q[c].pop_front();
	endfunction
	function automatic ihr_pkg::ihr_iq_t expv(int s);
		ihr_pkg::ihr_iq_t a, b;
		if (s % 2 == 1 && cc[1:0] > s / 2)
			return 'x;
		a = nxt(s);
		if (cc[1:0] <= s / 2)
			return a;
		b = nxt(s + 1);
		if (cc[2])
			return {sat(a.i + b.i), sat(a.q + b.q)};
		return {sat(a.i - b.q), sat(b.i + a.q)};
	endfunction
	task automatic chk(string n, logic [43:0] e, logic [43:0] g);
		total_checks++;
		if (e !== g)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	always @(negedge clk)
		for (int s = 0; s < 6; s++)
			if (rst_n && ov[s] && ar[s])
				chk("stream", expv(s), od[s]);
	task automatic run(logic [3:0] s, logic [2:0] c, logic [5:0] h, int n,
		logic [1:0] m);
		int cnt [6];
		int gap [6];
		logic [5:0] tk;
		logic go;
		@(posedge clk);
		#1 rst_n = 0;
		vld = 6'h0;
		sc = s;
		cc = c;
		md = m;
		foreach (mr[k]) mr[k] = 16'(xs()) & 16'hfdff | 16'(h[k]) << 9;
		foreach (hs[a, b]) hs[a][b] = '0;
		foreach (ptr[k]) ptr[k] = k;
		foreach (q[k]) q[k].delete();
		repeat (3) @(posedge clk);
		#1 rst_n = 1;
		chk("used", um, used);
		for (int t = 0; t < 3000 && (cnt.sum() < 6 * n || qs() > 0); t++)
		begin
			@(negedge clk);
			tk = vld & rdy;
			@(posedge clk);
			#1;
			if (m == 2'h2 && t == 100)
			begin
				chk("stall", 12'h03f, {rdy, ov});
				md = 2'h1;
			end
			for (int k = 0; k < 6; k++)
			begin
				if (tk[k])
					push(k, dat[k]);
				cnt[k] += tk[k];
				// spacing keeps half-band input under its rate limit
				gap[k] = tk[k] && mr[k][9] ? 2 : gap[k] > 0 ? gap[k] - 1 : 0;
				go = (tk[k] || !vld[k]) && gap[k] == 0 && cnt[k] < n;
				vld[k] = go || vld[k] && !tk[k];
				if (go)
					dat[k] = {22'(xs()), 22'(xs())};
			end
		end
		repeat (20) @(posedge clk);
		chk("left", 0, qs() + 6 * n - cnt.sum());
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#2500000;
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		run(4'hf, 3'h0, 6'h0, 40, 2'h2);
		run(4'hf, 3'h0, 6'h3f, 30, 2'h1);
		for (int k = 0; k < 10; k++)
			run(4'(k), 3'h0, {6{1'(xs())}}, 12, 2'h1);
		for (int k = 1; k < 8; k++)
			run(4'hf, 3'(k), {6{1'(xs())}}, 12, 2'(k & 1));
		run(4'hc, 3'h0, 6'(xs()), 12, 2'h0);
		print_verdict();
	end
endmodule // interp_halfband_output_router_tb_top
`default_nettype wire
